// File: nmi_smi_generator.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module nmi_smi_generator
#(
   parameter bit HAS_PROC_ERR  = 1'b1,
   parameter int PULSE_CYCLES  = nmi_pkg::PULSE_CYCLES
)
(
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   input  wire logic          front_panel_diag_interrupt,
   input  wire logic          filter_diag_hit,
   input  wire logic          processor_internal_error,
   input  wire logic          wdog_pretimeout_diag,
   input  wire logic          wdog_pretimeout_smi,
   input  wire logic          evbuf_msg_in,
   input  wire logic          nmi_line_sense,
   output logic               nmi_out,
   output logic               smi_out,
   output logic               diag_log_evt
);
   // =====================================================
   // reset release
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   wire rst_n = rst_sync_ff;

   // =====================================================
   // pin synchronisers
   localparam int NPIN = 7;
   wire  [NPIN-1:0] pin_raw = {nmi_line_sense, evbuf_msg_in, wdog_pretimeout_smi,
                               wdog_pretimeout_diag, processor_internal_error,
                               filter_diag_hit, front_panel_diag_interrupt};
   logic [NPIN-1:0] pin_meta_ff;
   logic [NPIN-1:0] pin_sync_ff;
   logic [NPIN-1:0] pin_prev_ff;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
         pin_prev_ff <= '0;
      end
      else
      begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end
   // edges only: a held button or a stuck level fires once
   wire  [NPIN-1:0] pin_rise = pin_sync_ff & ~pin_prev_ff;

   // =====================================================
   // apb decode
   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire rd       = acc & ~pwrite;
   wire hit_ctrl = (paddr == nmi_pkg::ADDR_CTRL);
   wire hit_stat = (paddr == nmi_pkg::ADDR_STATUS);
   wire hit_src  = (paddr == nmi_pkg::ADDR_SOURCE);
   wire hit_set  = (paddr == nmi_pkg::ADDR_SETSRC);
   wire hit_smie = (paddr == nmi_pkg::ADDR_SMI_EN);
   wire hit_smis = (paddr == nmi_pkg::ADDR_SMI_ST);
   wire mapped   = hit_ctrl | hit_stat | hit_src | hit_set | hit_smie | hit_smis;

   wire wr_ctrl  = wr & hit_ctrl;
   wire cmd_en   = wr_ctrl & pwdata[nmi_pkg::CTRL_EN_BIT];
   wire cmd_dis  = wr_ctrl & ~pwdata[nmi_pkg::CTRL_EN_BIT];
   wire cmd_diag = wr_ctrl & pwdata[nmi_pkg::CTRL_DIAG_BIT];
   wire cmd_csmi = wr_ctrl & pwdata[nmi_pkg::CTRL_CLRSMI_BIT];
   wire cmd_set  = wr & hit_set;
   wire src_read = rd & hit_src;

   // =====================================================
   // trigger gathering
   logic [nmi_pkg::SRC_W-1:0] trig;
   always_comb
   begin
      trig = '0;
      trig[nmi_pkg::SRC_CHASSIS]  = cmd_diag;
      trig[nmi_pkg::SRC_PANEL]    = pin_rise[0];
      trig[nmi_pkg::SRC_FILTER]   = pin_rise[1];
      trig[nmi_pkg::SRC_PROC_ERR] = HAS_PROC_ERR & pin_rise[2];
      trig[nmi_pkg::SRC_WATCHDOG] = pin_rise[3];
      trig[nmi_pkg::SRC_SETCMD]   = cmd_set;
   end
   // set-source also carries the cause bits written by the agent
   wire [nmi_pkg::SRC_W-1:0] set_bits = cmd_set ? pwdata[nmi_pkg::SRC_W-1:0] : '0;
   wire [nmi_pkg::SRC_W-1:0] new_src  = trig | set_bits;

   // =====================================================
   // enable, cause record, one-shot
   logic                      enable_ff;
   logic [nmi_pkg::SRC_W-1:0] src_ff;
   wire  [nmi_pkg::SRC_W-1:0] nxt_src = (src_read ? '0 : src_ff) | new_src;
   wire                       nxt_enable = cmd_en ? 1'b1 : (cmd_dis ? 1'b0 : enable_ff);

   pulse_if pif();
   assign pif.fire  = enable_ff & (|trig);
   assign pif.rearm = cmd_en;
   // a pulse starts when armed, or when spent but rearmed in the same cycle
   wire accept      = pif.armed | (pif.rearm & ~pif.active);

   nmi_pulse_gen #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse
   (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .pif   (pif)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_ff <= nmi_pkg::ENABLE_RST;
         src_ff    <= nmi_pkg::SRC_RST;
      end
      else
      begin
         enable_ff <= nxt_enable;
         src_ff    <= nxt_src;
      end
   end

   // =====================================================
   // management interrupt
   logic [1:0] smi_en_ff;
   logic [1:0] smi_st_ff;
   wire  [1:0] smi_trig = {pin_rise[5], pin_rise[4]} & smi_en_ff;
   wire  [1:0] nxt_smi_st = (cmd_csmi ? 2'h0 : smi_st_ff) | smi_trig;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smi_en_ff <= nmi_pkg::SMI_EN_RST;
         smi_st_ff <= 2'h0;
      end
      else
      begin
         if (wr & hit_smie)
            smi_en_ff <= pwdata[1:0];
         smi_st_ff <= nxt_smi_st;
      end
   end

   // =====================================================
   // outputs and read data
   logic [31:0] rdata_mux;
   always_comb
   begin
      rdata_mux = 32'h00000000;
      if (hit_ctrl)
         rdata_mux = {31'h0, enable_ff};
      else if (hit_stat)
         rdata_mux = {28'h0, pin_sync_ff[6], pif.armed, pif.active, enable_ff};
      else if (hit_src)
         rdata_mux = {26'h0, src_ff};
      else if (hit_smie)
         rdata_mux = {30'h0, smi_en_ff};
      else if (hit_smis)
         rdata_mux = {30'h0, smi_st_ff};
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready       <= 1'b0;
         prdata       <= 32'h00000000;
         pslverr      <= 1'b0;
         nmi_out      <= 1'b0;
         smi_out      <= 1'b0;
         diag_log_evt <= 1'b0;
      end
      else
      begin
         pready       <= psel & ~penable;
         prdata       <= (psel & ~penable & ~pwrite) ? rdata_mux : prdata;
         pslverr      <= psel & ~penable & ~mapped;
         nmi_out      <= pif.active;
         smi_out      <= |nxt_smi_st;
         // log every assertion except the chassis command path
         diag_log_evt <= pif.fire & accept & ~trig[nmi_pkg::SRC_CHASSIS];
      end
   end

   // =====================================================
   // checks
   gate_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!enable_ff && pif.armed) |=> pif.armed)
      else $error("trigger passed while disabled");
   src_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (|trig) |=> (src_ff & $past(trig)) == $past(trig))
      else $error("cause not latched");
   src_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (src_read && !(|new_src)) |=> src_ff == '0)
      else $error("read did not clear cause");
   accum_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!src_read) |=> (src_ff & $past(src_ff)) == $past(src_ff))
      else $error("cause bit lost");
   set_fires_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cmd_set && enable_ff && pif.armed) |=> ##1 nmi_out)
      else $error("set-source did not fire");
   smi_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (smi_st_ff == 2'h0 && smi_en_ff == 2'h0) |=> smi_st_ff == 2'h0)
      else $error("disabled smi cause set");
   nmi_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pif.active |=> nmi_out)
      else $error("nmi line not driven");
   chassis_nolog_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      trig[nmi_pkg::SRC_CHASSIS] |=> !diag_log_evt)
      else $error("chassis pulse logged");
endmodule

// File: nmi_pkg.sv
// Contract
// - diag pulse held at least 30 ms
// - one pulse, then disarmed until re-armed
// - enable command re-arms the one-shot
// - causes latched, returned on source read
// - reading cause record clears it
// - set-source command itself triggers the pulse
// - global enable gates every trigger
// - global enable resets to enabled, volatile
// - chassis diag request triggers, logs nothing
// - front panel button press triggers
// - event filter diag action triggers
// - processor internal error trigger, build option
// - watchdog pre-timeout diag action triggers
// - pulse the line, log each assertion
// - watchdog pre-timeout raises management interrupt
// - event buffer message raises management interrupt
// - each management trigger separately enabled
// - interrupt line level readable for diagnostics
package nmi_pkg;
   // =====================================================
   // register map
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_SOURCE  = 8'h08;
   localparam logic [7:0] ADDR_SETSRC  = 8'h0C;
   localparam logic [7:0] ADDR_SMI_EN  = 8'h10;
   localparam logic [7:0] ADDR_SMI_ST  = 8'h14;
   // =====================================================
   // ctrl bits (write side)
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_DIAG_BIT   = 1;
   localparam int CTRL_CLRSMI_BIT = 2;
   // cause bit positions
   localparam int SRC_W           = 6;
   localparam int SRC_CHASSIS     = 0;
   localparam int SRC_PANEL       = 1;
   localparam int SRC_FILTER      = 2;
   localparam int SRC_PROC_ERR    = 3;
   localparam int SRC_WATCHDOG    = 4;
   localparam int SRC_SETCMD      = 5;
   // management interrupt enables
   localparam int SMI_WDOG_BIT    = 0;
   localparam int SMI_EVBUF_BIT   = 1;
   // =====================================================
   // reset values and timing
   localparam logic              ENABLE_RST   = 1'b1;
   localparam logic [SRC_W-1:0]  SRC_RST      = 6'h00;
   localparam logic [1:0]        SMI_EN_RST   = 2'h0;
   localparam int  CLK_MHZ        = 200;
   localparam int  PULSE_MS       = 30;
   localparam int  PULSE_CYCLES   = PULSE_MS * 1000 * CLK_MHZ;
   localparam int  CNT_W          = 23;
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_PULSE = 2'b01,
      ST_SPENT = 2'b10
   } pulse_state_t;
endpackage

// File: pulse_if.sv
`timescale 1ns/1ps
interface pulse_if;
   logic fire;
   logic rearm;
   logic active;
   logic armed;
   modport ctrl
   (
      output fire,
      output rearm,
      input  active,
      input  armed
   );
   modport gen
   (
      input  fire,
      input  rearm,
      output active,
      output armed
   );
endinterface

// File: nmi_pulse_gen.sv
`timescale 1ns/1ps
module nmi_pulse_gen
#(
   parameter int PULSE_CYCLES = nmi_pkg::PULSE_CYCLES
)
(
   input  wire logic   clk,
   input  wire logic   rst_n,
   pulse_if.gen        pif
);
   // =====================================================
   // one-shot pulse timer
   nmi_pkg::pulse_state_t                 state_ff;
   nmi_pkg::pulse_state_t                 nxt_state;
   logic [nmi_pkg::CNT_W-1:0]             cnt_ff;
   logic [nmi_pkg::CNT_W-1:0]             nxt_cnt;
   wire                                   done = (cnt_ff == nmi_pkg::CNT_W'(PULSE_CYCLES - 1));

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         nmi_pkg::ST_IDLE:
         begin
            if (pif.fire)
            begin
               nxt_state = nmi_pkg::ST_PULSE;
               nxt_cnt   = '0;
            end
         end
         nmi_pkg::ST_PULSE:
         begin
            nxt_cnt = cnt_ff + 1'b1;
            if (done)
               nxt_state = nmi_pkg::ST_SPENT;
         end
         nmi_pkg::ST_SPENT:
         begin
            // a rearm and a trigger in one cycle must still fire
            if (pif.rearm && pif.fire)
            begin
               nxt_state = nmi_pkg::ST_PULSE;
               nxt_cnt   = '0;
            end
            else if (pif.rearm)
               nxt_state = nmi_pkg::ST_IDLE;
         end
         default:
            nxt_state = nmi_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= nmi_pkg::ST_IDLE;
         cnt_ff   <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   assign pif.active = (state_ff == nmi_pkg::ST_PULSE);
   assign pif.armed  = (state_ff == nmi_pkg::ST_IDLE);

   // pulse never ends early: count must reach full length first
   pulse_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(pif.active) |-> $past(cnt_ff) == nmi_pkg::CNT_W'(PULSE_CYCLES - 1))
      else $error("pulse ended short");
   no_refire_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == nmi_pkg::ST_SPENT && !pif.rearm) |=> !pif.active)
      else $error("pulse while disarmed");
   rearm_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == nmi_pkg::ST_SPENT && pif.rearm && !pif.fire) |=> pif.armed)
      else $error("rearm ignored");
   rearm_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == nmi_pkg::ST_SPENT && pif.rearm && pif.fire) |=> pif.active)
      else $error("rearm with trigger lost");
endmodule

// File: host_irq_model.sv
`timescale 1ns/1ps
// ======================================
// host side: line level and pulse monitor
module host_irq_model
(
   input  wire logic clk,
   input  wire logic nmi_in,
   output logic      line_level,
   output int        pulse_cnt,
   output int        last_width
);
   logic prev_ff = 1'b0;
   int   run_ff  = 0;
   // nothing else drives the line here, so it mirrors the device
   assign line_level = nmi_in;
   initial pulse_cnt = 0;
   initial last_width = 0;
   always @(posedge clk)
   begin
      prev_ff <= nmi_in;
      if (nmi_in && !prev_ff)
      begin
         pulse_cnt <= pulse_cnt + 1;
         run_ff <= 1;
      end
      else if (nmi_in)
         run_ff <= run_ff + 1;
      else if (prev_ff)
         last_width <= run_ff;
   end
endmodule

// File: nmi_smi_generator_bench.sv
`timescale 1ns/1ps
module nmi_smi_generator_bench;
   // ======================================
   // signals
   localparam int PULSE = 20;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic [5:0]  pins = 6'h00;
   logic        line_level;
   logic        nmi_out;
   logic        smi_out;
   logic        diag_log_evt;
   int          pulse_cnt;
   int          last_width;
   int          err_total = 0;
   int          check_count = 0;
   int          log_cnt = 0;
   int          cyc = 0;
   int          p0;
   int          l0;
   // ======================================
   // instances
   nmi_smi_generator #(.HAS_PROC_ERR(1'b1), .PULSE_CYCLES(PULSE)) nmi_smi_generator_inst
   (
      .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .front_panel_diag_interrupt(pins[0]), .filter_diag_hit(pins[1]),
      .processor_internal_error(pins[2]), .wdog_pretimeout_diag(pins[3]),
      .wdog_pretimeout_smi(pins[4]), .evbuf_msg_in(pins[5]), .nmi_line_sense(line_level),
      .nmi_out(nmi_out), .smi_out(smi_out), .diag_log_evt(diag_log_evt)
   );
   host_irq_model host_irq_model_inst
   (
      .clk(sys_clk), .nmi_in(nmi_out), .line_level(line_level),
      .pulse_cnt(pulse_cnt), .last_width(last_width)
   );
   // ======================================
   // clock, log counter, timeout
   initial
      forever #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (diag_log_evt === 1'b1)
         log_cnt <= log_cnt + 1;
      if (cyc == 5000)
      begin
         err_total++;
         wrap_up();
      end
   end
   // ======================================
   // shared tasks
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask
   // master holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      if (n >= 40)
         err_total++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x,
                        input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk(nm, r & m, x);
   endtask
   task automatic hit(input int i);
      pins[i] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      pins[i] <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic snap;
      p0 = pulse_cnt;
      l0 = log_cnt;
   endtask
   task automatic judge(input int dp, input int dl);
      repeat (PULSE + 15) @(posedge sys_clk);
      chk("pulses", pulse_cnt - p0, dp);
      chk("log events", log_cnt - l0, dl);
      if (dp > 0)
         chk("pulse width", last_width, PULSE);
   endtask
   // ======================================
   // scenarios
   task automatic t_reset;
      rdchk("ctrl", nmi_pkg::ADDR_CTRL, 32'h00000001);
      rdchk("status", nmi_pkg::ADDR_STATUS, 32'h00000005);
      rdchk("source", nmi_pkg::ADDR_SOURCE, 32'h00000000);
      rdchk("smi enables", nmi_pkg::ADDR_SMI_EN, 32'h00000000);
   endtask
   task automatic t_pins;
      for (int i = 0; i < 4; i++)
      begin
         wr(nmi_pkg::ADDR_CTRL, 32'h00000001);
         snap();
         hit(i);
         repeat (3) @(posedge sys_clk);
         rdchk("active and line", nmi_pkg::ADDR_STATUS, 32'h0000000B, 32'h0000000B);
         judge(1, 1);
         rdchk("cause", nmi_pkg::ADDR_SOURCE, 32'h00000001 << (i + 1));
         rdchk("cause cleared", nmi_pkg::ADDR_SOURCE, 32'h00000000);
      end
   endtask
   // the last pin pulse left the one-shot spent
   task automatic t_oneshot;
      snap();
      hit(1);
      hit(0);
      judge(0, 0);
      rdchk("armed", nmi_pkg::ADDR_STATUS, 32'h00000000, 32'h00000004);
      rdchk("accumulated", nmi_pkg::ADDR_SOURCE, 32'h00000006);
   endtask
   task automatic t_chassis;
      snap();
      wr(nmi_pkg::ADDR_CTRL, 32'h00000003);
      judge(1, 0);
      rdchk("chassis cause", nmi_pkg::ADDR_SOURCE, 32'h00000001);
   endtask
   task automatic t_disable;
      wr(nmi_pkg::ADDR_CTRL, 32'h00000000);
      rdchk("disabled", nmi_pkg::ADDR_CTRL, 32'h00000000);
      snap();
      hit(0);
      judge(0, 0);
      wr(nmi_pkg::ADDR_CTRL, 32'h00000001);
      snap();
      wr(nmi_pkg::ADDR_SETSRC, 32'h00000008);
      judge(1, 1);
      rdchk("set causes", nmi_pkg::ADDR_SOURCE, 32'h0000002A);
   endtask
   task automatic t_smi;
      hit(4);
      repeat (8) @(posedge sys_clk);
      chk("smi masked", 32'(smi_out), 32'h00000000);
      rdchk("smi status masked", nmi_pkg::ADDR_SMI_ST, 32'h00000000);
      wr(nmi_pkg::ADDR_SMI_EN, 32'h00000003);
      rdchk("smi enables", nmi_pkg::ADDR_SMI_EN, 32'h00000003);
      hit(4);
      repeat (8) @(posedge sys_clk);
      chk("smi watchdog", 32'(smi_out), 32'h00000001);
      rdchk("smi status wd", nmi_pkg::ADDR_SMI_ST, 32'h00000001);
      wr(nmi_pkg::ADDR_CTRL, 32'h00000005);
      repeat (3) @(posedge sys_clk);
      chk("smi cleared", 32'(smi_out), 32'h00000000);
      hit(5);
      repeat (8) @(posedge sys_clk);
      chk("smi buffer", 32'(smi_out), 32'h00000001);
      rdchk("smi status buf", nmi_pkg::ADDR_SMI_ST, 32'h00000002);
   endtask
   task automatic t_unmapped;
      logic [31:0] r;
      logic        e;
      apb(1'b1, 8'h40, 32'hFFFFFFFF, r, e);
      chk("write slverr", 32'(e), 32'h00000001);
      apb(1'b0, 8'h40, 32'h00000000, r, e);
      chk("read slverr", 32'(e), 32'h00000001);
      chk("read data", r, 32'h00000000);
   endtask
   initial
   begin
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_pins();
      t_oneshot();
      t_chassis();
      t_disable();
      t_smi();
      t_unmapped();
      wrap_up();
   end
endmodule
